/* File: rtl/pcdp_params.svh */
// Offsets, field positions, reset values and timing of the loader.
`ifndef PCDP_PARAMS_SVH
`define PCDP_PARAMS_SVH
`define PCDP_CTRL_OFF 8'h00
`define PCDP_IMAGE_OFF 8'h04
`define PCDP_KEY_OFF 8'h08
`define PCDP_STATUS_OFF 8'h0c
`define PCDP_COUNT_OFF 8'h10
`define PCDP_SUM_OFF 8'h14
`define PCDP_CTRL_WIDTH_LSB 0
`define PCDP_CTRL_DECOMP_BIT 2
`define PCDP_CTRL_SECURE_BIT 3
`define PCDP_CTRL_INITEN_BIT 4
`define PCDP_CTRL_RESET 32'h0000_0002
`define PCDP_IMAGE_RESET 32'h0000_0010
`define PCDP_POR_DELAY_NS 100000
`define PCDP_CLK_MHZ 100
`endif

/* File: rtl/pcdp_pkg.sv */
// Types shared by the parallel configuration loader.
package pcdp_pkg;
    typedef enum logic [2:0] {
        PCDP_POR, PCDP_HOLD, PCDP_LOAD, PCDP_INIT, PCDP_USER
    } pcdp_state_t;
    typedef enum logic [1:0] {PCDP_W8, PCDP_W16, PCDP_W32} pcdp_width_t;
endpackage

/* File: rtl/pcdp_loader.sv */
// Parallel configuration data port with an APB register slave.
//
// Contract
// - Ratio follows bus width, decompression, security.
// - Extra clock cycles decrypt and decompress data; here they only step the phase, and no data is decompressed.
// - User mode: request, health, completion high.
// - Request low starts a new configuration.
// - Health held low through power-on delay.
// - Completion low at power-up and loading.
// - Completion rises only after all data.
// - Two falling edges after completion enter user.
// - Clock ignored after configuration completes.
// - Enabled init output low until initialization.
//
// Added by the designer: the APB register port and the address map.
`timescale 1ns/1ps
`include "pcdp_params.svh"
module pcdp_loader
    import pcdp_pkg::*;
#(
    parameter int POR_CYCLES =
        `PCDP_POR_DELAY_NS * `PCDP_CLK_MHZ / 1000
)
(
    input wire logic mclk,
    input wire logic rstn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic reconfig_request_n,
    input wire logic cfg_clock,
    input wire logic [31:0] cfg_data,
    output logic cfg_health_n,
    output logic load_complete_flag,
    output logic init_done
);

////////////////////////////////////////////////////////////////////////
// Reset release and pin synchronisers.

logic rst_q1; // First stage of the reset release.
logic srstn; // Reset copy used by all other logic.
logic [33:0] pin_s1; // First sync stage, read only by pin_s2.
logic [33:0] pin_s2; // Second sync stage.
logic clk_d; // Delayed synced clock for edge finding.

// Reset asserts at once and releases two edges later.
always_ff @(posedge mclk or negedge rstn)
begin
    if (!rstn)
    begin
        rst_q1 <= 1'b0;
        srstn <= 1'b0;
    end
    else
    begin
        rst_q1 <= 1'b1;
        srstn <= rst_q1;
    end
end

// Host pins pass two flops; data and clock share one latency.
always_ff @(posedge mclk or negedge srstn)
begin
    if (!srstn)
    begin
        pin_s1 <= 34'h2_0000_0000; // Idle: request high, clock low.
        pin_s2 <= 34'h2_0000_0000; // No false edge after reset.
        clk_d <= 1'b0;
    end
    else
    begin
        pin_s1 <= {reconfig_request_n, cfg_clock, cfg_data};
        pin_s2 <= pin_s1;
        clk_d <= pin_s2[32];
    end
end

logic req_n; // Synced reconfiguration request, active low.
logic cfg_rise; // One-cycle pulse on a rising link clock edge.
logic cfg_fall; // One-cycle pulse on a falling link clock edge.
assign req_n = pin_s2[33];
assign cfg_rise = pin_s2[32] & ~clk_d;
assign cfg_fall = ~pin_s2[32] & clk_d;

////////////////////////////////////////////////////////////////////////
// Loader state.

pcdp_state_t state, next_state; // Sequencer state.
logic [31:0] por_cnt, next_por_cnt; // Power-on delay counter.
logic [2:0] phase, next_phase; // Link clock within one word.
logic [31:0] word, next_word; // Word captured at phase zero.
logic [31:0] word_cnt, next_word_cnt; // Words fully processed.
logic [31:0] sum, next_sum; // Running sum of decrypted words.
logic fall_cnt, next_fall_cnt; // Falling edges seen in init.
logic [31:0] ctrl, next_ctrl, image, key; // Software registers.
logic [3:0] ratio; // Link clocks per data word.
logic [31:0] cur; // Word being worked on this edge.
logic last; // This edge ends the word.

// Link clocks per word for the width and enables in force.
function automatic logic [3:0] ratio_of(logic [1:0] w, logic dc,
                                        logic sec);
    logic [3:0] r;
    r = 4'h1;
    case (pcdp_width_t'(w))
        PCDP_W8: r = dc ? 4'h2 : 4'h1;
        PCDP_W16: r = dc ? 4'h4 : (sec ? 4'h2 : 4'h1);
        PCDP_W32: r = dc ? 4'h8 : (sec ? 4'h4 : 4'h1);
        default: r = dc ? 4'h8 : (sec ? 4'h4 : 4'h1);
    endcase
    return r;
endfunction

// Data lanes above the chosen width are not part of the image.
function automatic logic [31:0] lane_mask(logic [1:0] w);
    case (pcdp_width_t'(w))
        PCDP_W8: return 32'h0000_00ff;
        PCDP_W16: return 32'h0000_ffff;
        default: return 32'hffff_ffff;
    endcase
endfunction

assign ratio = ratio_of(ctrl[`PCDP_CTRL_WIDTH_LSB+:2],
                        ctrl[`PCDP_CTRL_DECOMP_BIT],
                        ctrl[`PCDP_CTRL_SECURE_BIT]);
assign cur = (phase == 3'h0)
           ? (pin_s2[31:0] & lane_mask(ctrl[`PCDP_CTRL_WIDTH_LSB+:2]))
           : word;
assign last = ({1'b0, phase} == ratio - 4'h1);

// Next-state logic for the sequencer and the data path.
always_comb
begin
    next_state = state;
    next_por_cnt = por_cnt;
    next_phase = phase;
    next_word = word;
    next_word_cnt = word_cnt;
    next_sum = sum;
    next_fall_cnt = fall_cnt;
    case (state)
        PCDP_POR:
        begin
            // Health stays low for the whole power-on delay.
            next_por_cnt = por_cnt + 32'h1;
            if (por_cnt == 32'(POR_CYCLES - 1))
                next_state = PCDP_HOLD;
        end
        PCDP_HOLD:
        begin
            // Wait until the host lets go of the request.
            next_phase = 3'h0;
            next_word_cnt = 32'h0;
            next_sum = 32'h0;
            next_fall_cnt = 1'b0;
            if (req_n)
                next_state = PCDP_LOAD;
        end
        PCDP_LOAD:
        begin
            if (cfg_rise)
            begin
                // Phase zero takes the word; the last edge adds it to sum, XORed with key if secure.
                next_word = cur;
                next_phase = last ? 3'h0 : phase + 3'h1;
                if (last)
                begin
                    next_sum = sum + (ctrl[`PCDP_CTRL_SECURE_BIT]
                                      ? (cur ^ key) : cur);
                    next_word_cnt = word_cnt + 32'h1;
                    if (word_cnt + 32'h1 == image)
                        next_state = PCDP_INIT;
                end
            end
        end
        PCDP_INIT:
        begin
            // Two falling edges finish initialisation.
            if (cfg_fall)
            begin
                next_fall_cnt = 1'b1;
                if (fall_cnt)
                    next_state = PCDP_USER;
            end
        end
        // The link clock is not looked at in user mode.
        PCDP_USER: next_state = PCDP_USER;
        default: next_state = PCDP_HOLD;
    endcase
    // A low request restarts from any state after the delay.
    if (!req_n && state != PCDP_POR)
        next_state = PCDP_HOLD;
end

// Registers for the sequencer and the pins it drives.
always_ff @(posedge mclk or negedge srstn)
begin
    if (!srstn)
    begin
        state <= PCDP_POR;
        por_cnt <= 32'h0;
        phase <= 3'h0;
        word <= 32'h0;
        word_cnt <= 32'h0;
        sum <= 32'h0;
        fall_cnt <= 1'b0;
        cfg_health_n <= 1'b0;
        load_complete_flag <= 1'b0;
        init_done <= 1'b0;
    end
    else
    begin
        state <= next_state;
        por_cnt <= next_por_cnt;
        phase <= next_phase;
        word <= next_word;
        word_cnt <= next_word_cnt;
        sum <= next_sum;
        fall_cnt <= next_fall_cnt;
        // Pins follow the state they will stand beside.
        cfg_health_n <= (next_state != PCDP_POR)
                     && (next_state != PCDP_HOLD);
        load_complete_flag <= (next_state == PCDP_INIT)
                           || (next_state == PCDP_USER);
        // Next control value, so enabling the output drops it at once.
        init_done <= !next_ctrl[`PCDP_CTRL_INITEN_BIT]
                  || (next_state == PCDP_USER);
    end
end

////////////////////////////////////////////////////////////////////////
// APB slave: one wait state, then a registered answer.

logic [31:0] next_image, next_key, next_prdata;
logic next_pready, next_pslverr;
logic hit; // Address names a register.

// Register decode and read mux.
always_comb
begin
    next_ctrl = ctrl;
    next_image = image;
    next_key = key;
    next_prdata = prdata;
    next_pready = 1'b0;
    next_pslverr = 1'b0;
    hit = 1'b1;
    case (paddr)
        `PCDP_CTRL_OFF: next_prdata = ctrl;
        `PCDP_IMAGE_OFF: next_prdata = image;
        `PCDP_KEY_OFF: next_prdata = key;
        `PCDP_STATUS_OFF: next_prdata = {20'h0, ratio, phase,
            load_complete_flag, cfg_health_n, state};
        `PCDP_COUNT_OFF: next_prdata = word_cnt;
        `PCDP_SUM_OFF: next_prdata = sum;
        default:
        begin
            next_prdata = 32'h0;
            hit = 1'b0;
        end
    endcase
    if (psel && penable && !pready)
    begin
        next_pready = 1'b1;
        next_pslverr = !hit;
    end
    // Writes land at the edge where pready is seen high.
    if (psel && penable && pready && pwrite)
    begin
        case (paddr)
            `PCDP_CTRL_OFF: next_ctrl = {27'h0, pwdata[4:0]};
            `PCDP_IMAGE_OFF: next_image = pwdata;
            `PCDP_KEY_OFF: next_key = pwdata;
            default: next_key = key; // Other offsets are not writable.
        endcase
    end
end

// Register the bus answer and the software registers.
always_ff @(posedge mclk or negedge srstn)
begin
    if (!srstn)
    begin
        ctrl <= `PCDP_CTRL_RESET;
        image <= `PCDP_IMAGE_RESET;
        key <= 32'h0;
        prdata <= 32'h0;
        pready <= 1'b0;
        pslverr <= 1'b0;
    end
    else
    begin
        ctrl <= next_ctrl;
        image <= next_image;
        key <= next_key;
        prdata <= next_prdata;
        pready <= next_pready;
        pslverr <= next_pslverr;
    end
end

////////////////////////////////////////////////////////////////////////
// Checks.
chk_health_por: assert property (@(posedge mclk) disable iff (!srstn)
    state == PCDP_POR |=> !cfg_health_n || state != PCDP_POR)
    else $error("health released during power-on delay");
chk_user_levels: assert property (@(posedge mclk) disable iff (!srstn)
    state == PCDP_USER |-> cfg_health_n && load_complete_flag)
    else $error("user mode pins not high");
chk_done_low: assert property (@(posedge mclk) disable iff (!srstn)
    state == PCDP_LOAD |-> !load_complete_flag)
    else $error("completion high while loading");
chk_done_count: assert property (@(posedge mclk) disable iff (!srstn)
    $rose(load_complete_flag) |-> word_cnt == image)
    else $error("completion before all words");
chk_reconf_start: assert property (@(posedge mclk) disable iff (!srstn)
    !req_n && state == PCDP_USER |=> state == PCDP_HOLD
    ##1 !cfg_health_n)
    else $error("request low did not restart");
chk_init_edges: assert property (@(posedge mclk) disable iff (!srstn)
    state == PCDP_INIT && fall_cnt && cfg_fall && req_n
    |=> state == PCDP_USER)
    else $error("second falling edge missed");
chk_clk_ignore: assert property (@(posedge mclk) disable iff (!srstn)
    state == PCDP_USER && req_n |=> $stable(word_cnt))
    else $error("link clock acted on after completion");
chk_init_pin: assert property (@(posedge mclk) disable iff (!srstn)
    ctrl[`PCDP_CTRL_INITEN_BIT] && state != PCDP_USER
    |-> !init_done)
    else $error("init output high too early");
chk_ratio_step: assert property (@(posedge mclk) disable iff (!srstn)
    state == PCDP_LOAD && cfg_rise && !last && req_n
    |=> $stable(word_cnt) && phase == $past(phase) + 3'h1)
    else $error("word counted before ratio reached");
endmodule

/* File: test/pcdp_host.sv */
// Host model that drives the configuration link of the loader.
`timescale 1ns/1ps
module pcdp_host
(
    input wire logic mclk,
    output logic reconfig_request_n,
    output logic cfg_clock,
    output logic [31:0] cfg_data
);
    // Half period of the link clock in system cycles, giving 40 ns and an 80 ns period.
    localparam int HALF = 4;

    // The link clock stands low and the request high until a task runs.
    initial
    begin
        reconfig_request_n = 1'b1;
        cfg_clock = 1'b0;
        cfg_data = 32'h0;
    end

    ////////////////////////////////////////////////////////////////////
    // Holds the link clock at one level for half a period.
    task automatic half(input logic lvl);
        cfg_clock <= lvl;
        repeat (HALF) @(posedge mclk);
    endtask

    // Pulses the request low so that a fresh load begins.
    task automatic restart();
        reconfig_request_n <= 1'b0;
        repeat (8) @(posedge mclk);
        reconfig_request_n <= 1'b1;
        repeat (8) @(posedge mclk);
    endtask

    // Sends one word held over r clocks; data settles while low.
    task automatic word(input logic [31:0] d, input int r);
        cfg_data <= d;
        half(1'b0);
        for (int i = 0; i < r; i++)
        begin
            half(1'b1);
            // Once the hold runs out the bus shows the inverse.
            if (i == r - 1)
                cfg_data <= ~d;
            half(1'b0);
        end
    endtask

    // Stops the link clock low for a while, as a slow host would.
    task automatic pause(input int n);
        cfg_clock <= 1'b0;
        repeat (n) @(posedge mclk);
    endtask

    // Gives n whole clocks; the clock is never left floating.
    task automatic clocks(input int n);
        repeat (n)
        begin
            half(1'b1);
            half(1'b0);
        end
    endtask
endmodule

/* File: test/pcdp_loader_tb.sv */
// Self-checking bench of the parallel configuration loader.
`timescale 1ns/1ps
`include "pcdp_params.svh"
module pcdp_loader_tb;
    // A short power-on delay keeps the run brief.
    localparam int POR = 20;
    // Key for the security scenario; any value serves.
    localparam logic [31:0] KEY = 32'h3c96_a55a;
    logic mclk, rstn, psel, penable, pwrite, pready, pslverr;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, cfg_data;
    logic reconfig_request_n, cfg_clock;
    logic cfg_health_n, load_complete_flag, init_done;
    int n_errors, tests_run;

    pcdp_loader #(.POR_CYCLES(POR)) pcdp_loader_inst (.mclk(mclk),
        .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .reconfig_request_n(reconfig_request_n),
        .cfg_clock(cfg_clock), .cfg_data(cfg_data),
        .cfg_health_n(cfg_health_n),
        .load_complete_flag(load_complete_flag), .init_done(init_done));
    pcdp_host pcdp_host_inst (.mclk(mclk),
        .reconfig_request_n(reconfig_request_n), .cfg_clock(cfg_clock),
        .cfg_data(cfg_data));

    // System clock of 100 MHz.
    initial
    begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end

    ////////////////////////////////////////////////////////////////////
    // Compares one word and counts the outcome.
    task automatic check_word(input string what, input logic [31:0] exp,
                              input logic [31:0] got);
        tests_run++;
        if (got !== exp)
        begin
            n_errors++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask

    // Compares one flag and counts the outcome.
    task automatic check_flag(input string what, input logic exp,
                              input logic got);
        check_word(what, {31'h0, exp}, {31'h0, got});
    endtask

    // One APB transfer; the request stands until pready is sampled high.
    task automatic apb(input logic wr, input logic [7:0] a,
                       input logic [31:0] wd, output logic [31:0] rd,
                       output logic err);
        int n;
        n = 0;
        @(posedge mclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge mclk);
        penable <= 1'b1;
        do
        begin
            @(posedge mclk);
            n++;
        end
        while (pready !== 1'b1 && n < 20);
        check_flag("pready", 1'b1, pready);
        // A slave that never answers ends the run here.
        if (pready !== 1'b1)
            test_done();
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] v;
        logic e;
        apb(1'b1, a, d, v, e);
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        logic e;
        apb(1'b0, a, 32'h0, d, e);
    endtask

    // Expected clock-to-word ratio for a width code and the enables.
    function automatic logic [3:0] ratio(input int w, input bit dc,
                                         input bit sec);
        if (dc)
            return (w == 0) ? 4'h2 : (w == 1) ? 4'h4 : 4'h8;
        if (sec)
            return (w == 0) ? 4'h1 : (w == 1) ? 4'h2 : 4'h4;
        return 4'h1;
    endfunction

    ////////////////////////////////////////////////////////////////////
    // Reset values and an unmapped address, which must be refused.
    task automatic regs_scn();
        logic [31:0] v;
        logic e;
        rd(`PCDP_CTRL_OFF, v);
        check_word("ctrl reset", `PCDP_CTRL_RESET, v);
        rd(`PCDP_IMAGE_OFF, v);
        check_word("image reset", `PCDP_IMAGE_RESET, v);
        apb(1'b0, 8'h40, 32'h0, v, e);
        check_flag("unmapped error", 1'b1, e);
        check_word("unmapped data", 32'h0, v);
    endtask

    // Every width and enable pair sets the reported ratio.
    task automatic ratio_scn();
        logic [31:0] v;
        for (int k = 0; k < 12; k++)
        begin
            wr(`PCDP_CTRL_OFF, {27'h0, 1'b0, k[0], k[1], k[3:2]});
            rd(`PCDP_STATUS_OFF, v);
            check_word("ratio", {28'h0, ratio(k / 4, k[1], k[0])},
                       {28'h0, v[11:8]});
        end
    endtask

    // A full load with a pause, the trailing clocks and idle clocks.
    task automatic load_scn(input logic [1:0] w, input bit dc,
                            input bit sec, input bit ie, input int n);
        logic [31:0] v;
        int r;
        logic [31:0] d;
        logic [31:0] m;
        logic [31:0] exp_sum;
        r = int'(ratio(int'(w), dc, sec));
        // Lanes above the chosen width never reach the checksum.
        m = (w == 2'h0) ? 32'h0000_00ff
          : (w == 2'h1) ? 32'h0000_ffff : 32'hffff_ffff;
        exp_sum = 32'h0;
        wr(`PCDP_KEY_OFF, KEY);
        wr(`PCDP_IMAGE_OFF, 32'(n));
        wr(`PCDP_CTRL_OFF, {27'h0, ie, sec, dc, w});
        pcdp_host_inst.restart();
        check_flag("health on restart", 1'b1, cfg_health_n);
        rd(`PCDP_COUNT_OFF, v);
        check_word("count on restart", 32'h0, v);
        check_flag("init while loading", !ie, init_done);
        for (int i = 0; i < n; i++)
        begin
            check_flag("flag while loading", 1'b0,
                       load_complete_flag);
            d = (32'h5ac3_0f00 + 32'(i)) & m;
            exp_sum = exp_sum + (sec ? (d ^ KEY) : d);
            pcdp_host_inst.word(32'h5ac3_0f00 + 32'(i), r);
            if (i == 0)
                pcdp_host_inst.pause(30);
        end
        check_flag("flag after image", 1'b1, load_complete_flag);
        check_flag("init before user", !ie, init_done);
        pcdp_host_inst.clocks(2);
        repeat (4) @(posedge mclk);
        check_flag("init in user", 1'b1, init_done);
        rd(`PCDP_STATUS_OFF, v);
        check_word("state", 32'h4, {29'h0, v[2:0]});
        check_flag("health in user", 1'b1, cfg_health_n);
        check_flag("flag in user", 1'b1, load_complete_flag);
        pcdp_host_inst.clocks(3);
        rd(`PCDP_COUNT_OFF, v);
        check_word("count in user", 32'(n), v);
        rd(`PCDP_SUM_OFF, v);
        check_word("checksum", exp_sum, v);
    endtask

    ////////////////////////////////////////////////////////////////////
    // Prints the counts and the verdict, then ends the run.
    task automatic test_done();
        $display("checks %0d, errors %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    // Cuts a hang short well beyond the fewer than a thousand cycles needed.
    initial
    begin
        #200000;
        n_errors++;
        test_done();
    end

    // Main sequence: reset, power-on delay, then the scenarios.
    initial
    begin
        n_errors = 0;
        tests_run = 0;
        rstn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h0;
        pwdata = 32'h0;
        repeat (3) @(posedge mclk);
        rstn <= 1'b1;
        repeat (10) @(posedge mclk);
        check_flag("health in delay", 1'b0, cfg_health_n);
        check_flag("flag at power-up", 1'b0, load_complete_flag);
        repeat (POR + 10) @(posedge mclk);
        check_flag("health after delay", 1'b1, cfg_health_n);
        regs_scn();
        ratio_scn();
        load_scn(2'h2, 1'b1, 1'b0, 1'b1, 3);
        load_scn(2'h1, 1'b0, 1'b1, 1'b0, 2);
        load_scn(2'h0, 1'b0, 1'b0, 1'b1, 2);
        test_done();
    end
endmodule
